// file: rtl/pulse_timing_param_control.sv
// pulse timing parameter registers, interlocks and pulse timing generator
`timescale 1ns/1ps
`default_nettype none
`include "pulse_timing_defines.svh"
module pulse_timing_param_control
  import pulse_timing_pkg::*;
(
  input  wire logic        clk_i,      // 200 MHz clock
  input  wire logic        rst_i,      // sync reset, active high
  input  wire logic        wb_cyc_i,   // wishbone cycle
  input  wire logic        wb_stb_i,   // wishbone strobe
  input  wire logic        wb_we_i,    // wishbone write
  input  wire logic [5:0]  wb_adr_i,   // byte address
  input  wire logic [3:0]  wb_sel_i,   // byte enables
  input  wire logic [31:0] wb_dat_i,   // write data
  output logic      [31:0] wb_dat_o,   // read data
  output logic             wb_ack_o,   // acknowledge
  input  wire logic        trig_i,     // trigger pin
  input  wire logic        ext_i,      // external width pin
  output logic             pulse_o,    // pulse timing to output stage
  output logic      [31:0] lead_o,     // leading edge time, cycles
  output logic      [31:0] trail_o,    // trailing edge time, cycles
  output logic             err_o       // error flag level
);
  // limits in clock cycles
  localparam logic [31:0] PER_MIN  = 32'(`NS2CYC(`PER_MIN_NS));
  localparam logic [31:0] PER_MAX  = 32'(`NS2CYC(`PER_MAX_NS));
  localparam logic [31:0] WID_MIN  = 32'(`NS2CYC(`WID_MIN_NS));
  localparam logic [31:0] WID_MAX  = 32'(`NS2CYC(`WID_MAX_NS));
  localparam logic [31:0] DEL_MAX  = 32'(`NS2CYC(`DEL_MAX_NS));
  localparam logic [31:0] EDGE_MIN = 32'(`NS2CYC(`EDGE_MIN_NS));
  localparam logic [31:0] EDGE_MAX = 32'(`NS2CYC(`EDGE_MAX_NS));
  localparam logic [33:0] BAND_LO  = 34'(`NS2CYC(`BAND_LO_NS));
  localparam logic [33:0] BAND_HI  = 34'(`NS2CYC(`BAND_HI_NS));

  timing_s     cur_ff;      // committed timing
  timing_s     nxt_cand;    // candidate after this write
  hold_e       hold_ff;     // width or duty held
  logic        ext_ff;      // external width mode
  logic        dbl_ff;      // double pulse mode
  logic        track_ff;    // edge tracking
  logic [31:0] duty_ff;     // remembered duty, per mille
  logic [31:0] nxt_duty;    // candidate duty
  hold_e       nxt_hold;    // candidate hold
  logic        nxt_ext;     // candidate external mode
  logic        nxt_dbl;     // candidate double mode
  logic        nxt_track;   // candidate tracking
  logic        ext_lock;    // write refused by external mode
  logic        bad_val;     // candidate violates a limit
  logic        wr_stb;      // accepted write
  logic        rd_stb;      // accepted read
  logic        ack_ff;      // registered ack
  logic [31:0] rdat_ff;     // registered read data
  logic        rng_err_ff;  // sticky range error
  logic        ext_err_ff;  // sticky external lock error
  logic [7:0]  code_ff;     // last error code
  logic [31:0] wdat;        // write data masked by byte enables
  logic [41:0] duty_prod;   // period times duty
  logic [31:0] duty_wid;    // width from duty
  logic [33:0] tr_sum;      // tracked edge value
  logic        set_rng;     // range error this cycle
  logic        set_ext;     // lock error this cycle

  // accept a request once, ack in the next cycle
  assign wr_stb = wb_cyc_i & wb_stb_i & ~ack_ff & wb_we_i;
  assign rd_stb = wb_cyc_i & wb_stb_i & ~ack_ff & ~wb_we_i;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign err_o = rng_err_ff | ext_err_ff;

  // unselected bytes keep the stored value of the addressed register
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (wb_sel_i[i]) begin
        r[i*8 +: 8] = wb_dat_i[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // edge pair is in one decade band and within ratio
  function automatic logic edges_ok(input logic [31:0] a, input logic [31:0] b);
    logic        band;
    logic [33:0] lo;
    logic [33:0] hi;
    logic [33:0] mn;
    logic [33:0] mx;
    band = 1'b0;
    lo = BAND_LO;
    hi = BAND_HI;
    mn = (a < b) ? {2'b00, a} : {2'b00, b};
    mx = (a < b) ? {2'b00, b} : {2'b00, a};
    for (int k = 0; k < `BAND_CNT; k++) begin
      if (mn >= lo && mx <= hi) begin
        band = 1'b1;
      end
      lo = 34'(lo * 34'd10);
      hi = 34'(hi * 34'd10);
    end
    return band && (mx <= 34'(mn * `EDGE_RATIO));
  endfunction

  // candidate settings for the addressed write
  always_comb begin
    wdat      = 32'h00000000;
    tr_sum    = 34'h000000000;
    nxt_cand  = cur_ff;
    nxt_duty  = duty_ff;
    nxt_hold  = hold_ff;
    nxt_ext   = ext_ff;
    nxt_dbl   = dbl_ff;
    nxt_track = track_ff;
    ext_lock  = 1'b0;
    if (wb_adr_i == `ADR_CTRL) begin
      wdat = merge({28'h0000000, track_ff, dbl_ff, ext_ff, hold_ff == HOLD_DUTY});
      nxt_hold  = wdat[`CTRL_HOLD] ? HOLD_DUTY : HOLD_WIDTH;
      nxt_ext   = wdat[`CTRL_EXT];
      nxt_dbl   = wdat[`CTRL_DBL];
      nxt_track = wdat[`CTRL_TRACK];
      ext_lock  = nxt_dbl & nxt_ext;  // never both modes at once
    end else if (wb_adr_i == `ADR_PER) begin
      nxt_cand.per = merge(cur_ff.per);
      ext_lock = ext_ff;
    end else if (wb_adr_i == `ADR_WID) begin
      nxt_cand.wid = merge(cur_ff.wid);
      nxt_hold = HOLD_WIDTH;
      ext_lock = ext_ff;
    end else if (wb_adr_i == `ADR_DEL || wb_adr_i == `ADR_DEL2) begin
      nxt_cand.del = merge(cur_ff.del);
      ext_lock = ext_ff;
    end else if (wb_adr_i == `ADR_DUTY) begin
      nxt_duty = merge(duty_ff);
      nxt_hold = HOLD_DUTY;
      ext_lock = ext_ff;
    end else if (wb_adr_i == `ADR_LEAD) begin
      nxt_cand.lead = merge(cur_ff.lead);
      tr_sum = {2'b00, cur_ff.trail} + {2'b00, nxt_cand.lead} - {2'b00, cur_ff.lead};
      if (track_ff) begin
        nxt_cand.trail = tr_sum[31:0];
      end
    end else if (wb_adr_i == `ADR_TRAIL) begin
      nxt_cand.trail = merge(cur_ff.trail);
      tr_sum = {2'b00, cur_ff.lead} + {2'b00, nxt_cand.trail} - {2'b00, cur_ff.trail};
      if (track_ff) begin
        nxt_cand.lead = tr_sum[31:0];
      end
    end
    // width derived from the candidate period and duty
    duty_prod = 42'({10'd0, nxt_cand.per} * {10'd0, nxt_duty});
    duty_wid  = 32'(duty_prod / `DUTY_SCALE);
    // duty hold recomputes width on any change, restoring the kept ratio
    if (nxt_hold == HOLD_DUTY) begin
      nxt_cand.wid = duty_wid;
    end
  end

  // ranges and interlocks on the whole candidate
  always_comb begin
    bad_val = 1'b0;
    if (nxt_cand.per < PER_MIN || nxt_cand.per > PER_MAX) begin
      bad_val = 1'b1;
    end
    if (nxt_cand.wid < WID_MIN || nxt_cand.wid > WID_MAX) begin
      bad_val = 1'b1;
    end
    if (nxt_cand.del > DEL_MAX) begin
      bad_val = 1'b1;
    end
    if (nxt_cand.lead < EDGE_MIN || nxt_cand.lead > EDGE_MAX) begin
      bad_val = 1'b1;
    end
    if (nxt_cand.trail < EDGE_MIN || nxt_cand.trail > EDGE_MAX) begin
      bad_val = 1'b1;
    end
    if (tr_sum[33:32] != 2'b00 && track_ff) begin
      bad_val = 1'b1;  // tracked edge went negative or too large
    end
    if (!edges_ok(nxt_cand.lead, nxt_cand.trail)) begin
      bad_val = 1'b1;
    end
    if (nxt_duty < `DUTY_MIN || nxt_duty > `DUTY_MAX) begin
      bad_val = 1'b1;
    end
    // the whole pulse with both edges fits in the period
    if ({2'b00, nxt_cand.del} + {2'b00, nxt_cand.wid} + {2'b00, nxt_cand.lead}
        + {2'b00, nxt_cand.trail} > {2'b00, nxt_cand.per}) begin
      bad_val = 1'b1;
    end
    // second pulse must not start before the first one ends
    if (nxt_dbl && {2'b00, nxt_cand.wid} + {2'b00, nxt_cand.lead}
        + {2'b00, nxt_cand.trail} > {2'b00, nxt_cand.del}) begin
      bad_val = 1'b1;
    end
  end

  assign set_ext = wr_stb & ext_lock & (wb_adr_i != `ADR_STAT);
  assign set_rng = wr_stb & ~ext_lock & bad_val & (wb_adr_i != `ADR_STAT);

  // commit candidate only when it is clean
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_ff   <= '{`RST_PER, `RST_WID, `RST_DEL, `RST_EDGE, `RST_EDGE};
      duty_ff  <= `RST_DUTY;
      hold_ff  <= HOLD_WIDTH;
      ext_ff   <= 1'b0;
      dbl_ff   <= 1'b0;
      track_ff <= 1'b0;
    end else if (wr_stb && !ext_lock && !bad_val && wb_adr_i != `ADR_STAT) begin
      cur_ff   <= nxt_cand;
      duty_ff  <= nxt_duty;
      hold_ff  <= nxt_hold;
      ext_ff   <= nxt_ext;
      dbl_ff   <= nxt_dbl;
      track_ff <= nxt_track;
    end
  end

  // sticky errors, a new error wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rng_err_ff <= 1'b0;
      ext_err_ff <= 1'b0;
      code_ff    <= 8'h00;
    end else begin
      if (wr_stb && wb_adr_i == `ADR_STAT && wb_sel_i[0]) begin
        rng_err_ff <= rng_err_ff & ~wb_dat_i[0];
        ext_err_ff <= ext_err_ff & ~wb_dat_i[1];
      end
      if (set_rng) begin
        rng_err_ff <= 1'b1;
        code_ff    <= `ERR_RNG_CODE;
      end
      if (set_ext) begin
        ext_err_ff <= 1'b1;
        code_ff    <= `ERR_EXT_CODE;
      end
    end
  end

  // bus ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      if (rd_stb) begin
        if (wb_adr_i == `ADR_CTRL) begin
          rdat_ff <= {28'h0000000, track_ff, dbl_ff, ext_ff, hold_ff == HOLD_DUTY};
        end else if (wb_adr_i == `ADR_PER) begin
          rdat_ff <= cur_ff.per;
        end else if (wb_adr_i == `ADR_WID) begin
          rdat_ff <= cur_ff.wid;
        end else if (wb_adr_i == `ADR_DEL || wb_adr_i == `ADR_DEL2) begin
          rdat_ff <= cur_ff.del;
        end else if (wb_adr_i == `ADR_DUTY) begin
          rdat_ff <= (hold_ff == HOLD_DUTY) ? duty_ff : 32'h00000000;
        end else if (wb_adr_i == `ADR_LEAD) begin
          rdat_ff <= cur_ff.lead;
        end else if (wb_adr_i == `ADR_TRAIL) begin
          rdat_ff <= cur_ff.trail;
        end else if (wb_adr_i == `ADR_STAT) begin
          rdat_ff <= {16'h0000, code_ff, 6'h00, ext_err_ff, rng_err_ff};
        end else begin
          rdat_ff <= 32'h00000000;  // unmapped reads zero
        end
      end
    end
  end

  logic [2:0] trig_sync_ff;  // trigger synchroniser
  logic [2:0] ext_sync_ff;   // external pulse synchroniser
  logic       trig_lvl_ff;   // filtered trigger level
  logic       ext_lvl_ff;    // filtered external level
  logic       trig_rise;     // trigger event

  // three flops, change accepted when last two agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_sync_ff <= 3'h0;
      ext_sync_ff  <= 3'h0;
      trig_lvl_ff  <= 1'b0;
      ext_lvl_ff   <= 1'b0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[1:0], trig_i};
      ext_sync_ff  <= {ext_sync_ff[1:0], ext_i};
      if (trig_sync_ff[1] == trig_sync_ff[2]) begin
        trig_lvl_ff <= trig_sync_ff[2];
      end
      if (ext_sync_ff[1] == ext_sync_ff[2]) begin
        ext_lvl_ff <= ext_sync_ff[2];
      end
    end
  end

  assign trig_rise = (trig_sync_ff[1] == trig_sync_ff[2]) & trig_sync_ff[2] & ~trig_lvl_ff;

  gen_e        gen_ff;   // generator state
  logic [31:0] cnt_ff;   // cycles since trigger
  logic        pulse_ff; // pulse level
  logic        in_first; // inside first pulse window
  logic        in_del;   // inside delayed pulse window

  assign in_first = cnt_ff < cur_ff.wid;
  assign in_del = cnt_ff >= cur_ff.del && ({1'b0, cnt_ff} < {1'b0, cur_ff.del} + {1'b0, cur_ff.wid});

  // one period per trigger, triggers during a period are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_ff <= GEN_IDLE;
      cnt_ff <= 32'h00000000;
    end else begin
      case (gen_ff)
        GEN_IDLE: begin
          if (trig_rise && !ext_ff) begin
            gen_ff <= GEN_RUN;
            cnt_ff <= 32'h00000000;
          end
        end
        GEN_RUN: begin
          if (cnt_ff >= cur_ff.per - 32'h00000001) begin
            gen_ff <= GEN_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 32'h00000001;
          end
        end
        default: gen_ff <= GEN_IDLE;
      endcase
    end
  end

  // pulse level and edge times to output stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_ff <= 1'b0;
      lead_o   <= `RST_EDGE;
      trail_o  <= `RST_EDGE;
    end else begin
      lead_o  <= cur_ff.lead;
      trail_o <= cur_ff.trail;
      if (ext_ff) begin
        pulse_ff <= ext_lvl_ff;
      end else if (gen_ff != GEN_RUN) begin
        pulse_ff <= 1'b0;
      end else if (dbl_ff) begin
        pulse_ff <= in_first | in_del;
      end else begin
        pulse_ff <= in_del;
      end
    end
  end
  assign pulse_o = pulse_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ext_refuse: assert property (set_ext |=> $stable(cur_ff) && ext_err_ff)
    else $error("external lock did not refuse");
  chk_ext_code: assert property (set_ext |=> code_ff == 8'hDD)
    else $error("wrong lock error code");
  chk_bad_keep: assert property (set_rng |=> $stable(cur_ff) && rng_err_ff)
    else $error("bad value was committed");
  chk_no_dbl_ext: assert property (!(dbl_ff && ext_ff))
    else $error("double with external mode");
  chk_duty_zero: assert property (rd_stb && wb_adr_i == `ADR_DUTY && hold_ff == HOLD_WIDTH
    |=> rdat_ff == 32'h00000000)
    else $error("duty read not zero");
  chk_wid_write: assert property (wr_stb && wb_adr_i == `ADR_WID && !ext_lock && !bad_val
    |=> hold_ff == HOLD_WIDTH)
    else $error("width write left duty hold");
  chk_edge_range: assert property (cur_ff.lead >= EDGE_MIN && cur_ff.lead <= EDGE_MAX
    && cur_ff.trail >= EDGE_MIN && cur_ff.trail <= EDGE_MAX)
    else $error("edge out of range");
  chk_edge_ratio: assert property ({2'b00, cur_ff.lead} <= 34'(cur_ff.trail * `EDGE_RATIO)
    && {2'b00, cur_ff.trail} <= 34'(cur_ff.lead * `EDGE_RATIO))
    else $error("edge ratio over limit");
  chk_per_range: assert property (cur_ff.per >= PER_MIN && cur_ff.per <= PER_MAX
    && cur_ff.wid >= WID_MIN && cur_ff.del <= DEL_MAX)
    else $error("timing out of range");
  chk_track_lead: assert property (wr_stb && wb_adr_i == `ADR_LEAD && track_ff && !bad_val
    |=> cur_ff.trail - $past(cur_ff.trail) == cur_ff.lead - $past(cur_ff.lead))
    else $error("trail did not follow lead");
  chk_single_start: assert property (gen_ff == GEN_RUN && !dbl_ff && !ext_ff
    && cnt_ff == cur_ff.del && $stable(cnt_ff) == 1'b0 |=> pulse_o)
    else $error("pulse not started after delay");
  chk_duty_width: assert property (hold_ff == HOLD_DUTY |-> cur_ff.wid == 32'(
    ({10'd0, cur_ff.per} * {10'd0, duty_ff}) / `DUTY_SCALE))
    else $error("width not tracking duty");

  cov_single: cover property (gen_ff == GEN_RUN && !dbl_ff ##1 pulse_o);
  cov_double: cover property (dbl_ff && pulse_o ##1 !pulse_o ##[1:400] pulse_o);
  cov_ext_ref: cover property (set_ext);
  cov_duty_on: cover property (hold_ff == HOLD_WIDTH ##1 hold_ff == HOLD_DUTY);
endmodule
`default_nettype wire

// file: rtl/pulse_timing_defines.svh
// constants for the pulse timing parameter block
// Overview of operation
// - width 10 ns to 9.89999 s, interlocked
// - single pulse starts delay after trigger
// - both delay writes share one value
// - delay accepted only within interlock range
// - duty write sets duty hold, tracks period
// - width write or width hold ends duty
// - duty read returns zero when hold off
// - hold selector width or duty, readable
// - last duty kept, restored on duty hold
// - external mode copies external pulse width
// - external mode refuses timing writes, code 221; lead and trail writes are still accepted
// - double pulse refused in external mode
// - double: pulse at trigger, second after delay
// - leading edge 5 ns to 10 ms
// - trailing edge 5 ns to 10 ms
// - tracking: lead change copied to trail
// - tracking: trail change copied to lead
// - edge ratio at most 20 to 1
// - both edges in one decade band
// - period 20 ns to 10 s, interlocked
`ifndef PULSE_TIMING_DEFINES_SVH
`define PULSE_TIMING_DEFINES_SVH
`define CLK_PS        64'd5000
`define NS2CYC(ns)    (((ns) * 64'd1000) / `CLK_PS)
`define PER_MIN_NS    64'd20
`define PER_MAX_NS    64'd10000000000
`define WID_MIN_NS    64'd10
`define WID_MAX_NS    64'd9899990000
`define DEL_MAX_NS    64'd9800000000
`define EDGE_MIN_NS   64'd5
`define EDGE_MAX_NS   64'd10000000
`define BAND_LO_NS    64'd5
`define BAND_HI_NS    64'd100
`define BAND_CNT      6
`define EDGE_RATIO    34'd20
`define DUTY_MIN      32'h0000000A
`define DUTY_MAX      32'h000003DE
`define DUTY_SCALE    42'd1000
`define ERR_EXT_CODE  8'hDD
`define ERR_RNG_CODE  8'hDE
`define ADR_CTRL      6'h00
`define ADR_PER       6'h04
`define ADR_WID       6'h08
`define ADR_DEL       6'h0C
`define ADR_DEL2      6'h10
`define ADR_DUTY      6'h14
`define ADR_LEAD      6'h18
`define ADR_TRAIL     6'h1C
`define ADR_STAT      6'h20
`define CTRL_HOLD     0
`define CTRL_EXT      1
`define CTRL_DBL      2
`define CTRL_TRACK    3
`define RST_PER       32'h000000C8
`define RST_WID       32'h00000014
`define RST_DEL       32'h00000000
`define RST_EDGE      32'h00000001
`define RST_DUTY      32'h000001F4
`endif

// file: rtl/pulse_timing_pkg.sv
// types for the pulse timing parameter block
package pulse_timing_pkg;
  typedef enum logic {HOLD_WIDTH, HOLD_DUTY} hold_e;
  typedef enum logic {GEN_IDLE, GEN_RUN} gen_e;
  typedef struct packed {
    logic [31:0] per;
    logic [31:0] wid;
    logic [31:0] del;
    logic [31:0] lead;
    logic [31:0] trail;
  } timing_s;
endpackage

// file: testbench/pulse_host_model.sv
// host-side wishbone master model for the pulse timing block
`timescale 1ns/1ps
`default_nettype none
module pulse_host_model (
  input  wire logic        clk_i,  // bus clock
  input  wire logic        ack_i,  // slave acknowledge
  output logic             cyc_o,  // bus cycle
  output logic             stb_o,  // strobe
  output logic             we_o,   // write when high
  output logic      [5:0]  adr_o,  // byte address
  output logic      [3:0]  sel_o,  // byte enables
  output logic      [31:0] dat_o   // write data
);
  // idle bus from time zero
  initial begin
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    adr_o <= 6'h3F;
    sel_o <= 4'hF;
    dat_o <= 32'h0;
  end
  // one classic cycle: raise after an edge, hold until ack, then release
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    // released address and data lines show no stale value
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the pulse timing parameter block
`timescale 1ns/1ps
`default_nettype none
`include "pulse_timing_defines.svh"
module tb;
  logic        clk_i, rst_i, trig_i, ext_i;    // clock, reset, pins
  logic        cyc, stb, we, ack, pulse, err;  // bus and outputs
  logic [5:0]  adr;                            // bus address
  logic [3:0]  sel;                            // byte enables
  logic [31:0] dat_w, dat_r, lead, trail;      // bus data, edge times
  logic [31:0] rd_q[$], pw_q[$];               // expected reads, widths
  string       nm_q[$];                        // names of pending reads
  int          errors, n_tests, rnd, t0;       // counters, scratch
  int          hi_cnt = 0, cyc_n = 0, rise_t = 0, gap = 0;  // pulse monitor state

  pulse_timing_param_control u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .trig_i(trig_i), .ext_i(ext_i),
    .pulse_o(pulse), .lead_o(lead), .trail_o(trail), .err_o(err));
  pulse_host_model u_host (
    .clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(dat_w));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // compare and count
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [31:0] d);
    u_host.xfer(1'b1, a, d, 4'hF);
  endtask
  // note the expected word, then read
  task automatic rd(logic [5:0] a, logic [31:0] e);
    rd_q.push_back(e);
    nm_q.push_back($sformatf("reg %h", a));
    u_host.xfer(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic close_out();
    chk("pending", 32'h0, 32'(rd_q.size() + pw_q.size()));
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // read data is taken at the ack edge
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0)
      chk(nm_q.pop_front(), rd_q.pop_front(), dat_r);
  end
  // pulse width and rise spacing on the output
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (pulse === 1'b1) begin
      if (hi_cnt == 0) begin
        gap    <= cyc_n - rise_t;
        rise_t <= cyc_n;
      end
      hi_cnt <= hi_cnt + 1;
    end else if (hi_cnt != 0) begin
      chk("width", pw_q.size() ? pw_q.pop_front() : 32'hFFFFFFFF, 32'(hi_cnt));
      hi_cnt <= 0;
    end
  end
  // watchdog
  initial begin
    #100000;
    errors++;
    $display("ERROR watchdog expected done seen hang");
    close_out();
  end
  initial begin
    {errors, n_tests} = '0;
    rst_i  = 1'b1;
    trig_i = 1'b0;
    ext_i  = 1'b0;
    rnd    = $urandom(27944);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ADR_PER, `RST_PER);
    rd(`ADR_WID, `RST_WID);
    rd(`ADR_DEL2, `RST_DEL);
    rd(`ADR_LEAD, `RST_EDGE);
    rd(`ADR_TRAIL, `RST_EDGE);
    rd(`ADR_DUTY, 32'h0);
    rd(`ADR_CTRL, 32'h0);
    rd(6'h24, 32'h0);
    $display("test reset done");
    wr(`ADR_WID, 32'h1);
    rd(`ADR_WID, `RST_WID);
    rd(`ADR_STAT, 32'h0000DE01);
    chk("err_o", 32'h1, {31'h0, err});
    wr(`ADR_STAT, 32'h3);
    rnd = 2 + int'($urandom % 97);
    wr(`ADR_WID, 32'(rnd));
    rd(`ADR_WID, 32'(rnd));
    chk("err_o", 32'h0, {31'h0, err});
    wr(`ADR_PER, 32'h3);
    rd(`ADR_PER, `RST_PER);
    wr(`ADR_PER, 32'h64);
    rd(`ADR_PER, 32'h64);
    u_host.xfer(1'b1, `ADR_PER, 32'hFFFFFF78, 4'h1);
    rd(`ADR_PER, 32'h78);
    wr(`ADR_PER, 32'h64);
    $display("test ranges done");
    wr(`ADR_DUTY, 32'hFA);
    rd(`ADR_CTRL, 32'h1);
    rd(`ADR_WID, 32'h19);
    wr(`ADR_PER, 32'hC8);
    rd(`ADR_WID, 32'h32);
    wr(`ADR_DUTY, 32'h9);
    wr(`ADR_DUTY, 32'h3DF);
    rd(`ADR_DUTY, 32'hFA);
    wr(`ADR_WID, 32'h1E);
    rd(`ADR_CTRL, 32'h0);
    rd(`ADR_DUTY, 32'h0);
    wr(`ADR_PER, 32'h64);
    rd(`ADR_WID, 32'h1E);
    wr(`ADR_CTRL, 32'h1);
    rd(`ADR_DUTY, 32'hFA);
    rd(`ADR_WID, 32'h19);
    wr(`ADR_CTRL, 32'h0);
    wr(`ADR_WID, 32'h1E);
    $display("test hold done");
    wr(`ADR_DEL2, 32'h28);
    rd(`ADR_DEL, 32'h28);
    wr(`ADR_DEL, 32'h45);
    rd(`ADR_DEL2, 32'h28);
    wr(`ADR_DEL, 32'h44);
    rd(`ADR_DEL, 32'h44);
    wr(`ADR_DEL, 32'h28);
    $display("test delay done");
    wr(`ADR_LEAD, 32'h0);
    rd(`ADR_LEAD, 32'h1);
    wr(`ADR_TRAIL, 32'h0);
    rd(`ADR_TRAIL, 32'h1);
    wr(`ADR_LEAD, 32'h14);
    rd(`ADR_LEAD, 32'h14);
    wr(`ADR_LEAD, 32'h5);
    wr(`ADR_TRAIL, 32'h15);
    rd(`ADR_TRAIL, 32'h1);
    wr(`ADR_CTRL, 32'h8);
    wr(`ADR_LEAD, 32'h9);
    rd(`ADR_TRAIL, 32'h5);
    wr(`ADR_TRAIL, 32'h3);
    rd(`ADR_LEAD, 32'h7);
    chk("lead_o", 32'h7, lead);
    chk("trail_o", 32'h3, trail);
    wr(`ADR_CTRL, 32'h0);
    wr(`ADR_LEAD, 32'h1);
    wr(`ADR_TRAIL, 32'h1);
    $display("test edges done");
    wr(`ADR_STAT, 32'h3);
    wr(`ADR_CTRL, 32'h2);
    wr(`ADR_PER, 32'h32);
    rd(`ADR_PER, 32'h64);
    rd(`ADR_STAT, 32'h0000DD02);
    wr(`ADR_CTRL, 32'h6);
    rd(`ADR_CTRL, 32'h2);
    rnd = 3 + int'($urandom % 20);
    pw_q.push_back(32'(rnd));
    ext_i <= 1'b1;
    repeat (rnd) @(posedge clk_i);
    ext_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    wr(`ADR_CTRL, 32'h0);
    wr(`ADR_STAT, 32'h3);
    $display("test external done");
    pw_q.push_back(32'h1E);
    @(posedge clk_i);
    t0 = cyc_n;
    trig_i <= 1'b1;
    repeat (120) @(posedge clk_i);
    trig_i <= 1'b0;
    chk("delay", 32'h1, 32'(rise_t - t0 >= 41 && rise_t - t0 <= 47));
    wr(`ADR_CTRL, 32'h4);
    pw_q.push_back(32'h1E);
    pw_q.push_back(32'h1E);
    trig_i <= 1'b1;
    repeat (120) @(posedge clk_i);
    trig_i <= 1'b0;
    chk("gap", 32'h28, 32'(gap));
    $display("test pulses done");
    close_out();
  end
endmodule
`default_nettype wire
